// ===== flb_pkg.sv
// Purpose: constants shared by the flash lock, nv bit and boot map logic
// Assumes: 100 MHz pclk, 32-bit APB register bus
// Notes:   register offsets are byte addresses
package flb_pkg;
  // ****************************************************************
  // flash organisation
  // ****************************************************************
  localparam int PAGE_BYTES   = 512;
  localparam int PAGE_WORDS   = 128;
  localparam int REGION_PAGES = 32;
  localparam int REGIONS_DEF  = 32;
  localparam int PAGE_W       = 11;
  localparam int WADDR_W      = 18;
  localparam int LINE_W       = 128;
  localparam int NV_SEC       = 0;
  localparam int NV_BOD       = 1;
  localparam int NV_BODRST    = 2;
  localparam int NV_BOOT      = 3;
  localparam logic [3:0]  NV_RESET   = 4'h0;
  localparam logic [31:0] LOCK_RESET = 32'h0000_0000;
  // ****************************************************************
  // register map
  // ****************************************************************
  localparam logic [7:0] OFS_CMD    = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_RESULT = 8'h08;
  localparam logic [7:0] OFS_LOCKS  = 8'h0C;
  localparam logic [7:0] OFS_NVBITS = 8'h10;
  localparam logic [7:0] OFS_BOOT   = 8'h14;
  localparam int ST_READY = 0;
  localparam int ST_ABORT = 1;
  localparam int ST_SEC   = 2;
  localparam int ST_FPP   = 3;
  // ****************************************************************
  // commands
  // ****************************************************************
  localparam logic [7:0] CMD_DESC = 8'h00;
  localparam logic [7:0] CMD_WP   = 8'h01;
  localparam logic [7:0] CMD_EWP  = 8'h03;
  localparam logic [7:0] CMD_EA   = 8'h05;
  localparam logic [7:0] CMD_SLB  = 8'h08;
  localparam logic [7:0] CMD_CLB  = 8'h09;
  localparam logic [7:0] CMD_SNV  = 8'h0B;
  localparam logic [7:0] CMD_CNV  = 8'h0C;
  localparam logic [7:0] CMD_RD   = 8'h10;
  localparam logic [1:0] BOOT_ROM   = 2'h0;
  localparam logic [1:0] BOOT_FLASH = 2'h1;
  localparam logic [1:0] BOOT_SRAM  = 2'h2;
  localparam logic [3:0] BOOT_TOP   = 4'h0;
  localparam logic [15:0] ROM_SLOT  = 16'h4000;
  typedef enum logic [1:0] {S_IDLE, S_ARR, S_DONE} flb_state_t;
endpackage

// ===== flb_wide_read.sv
// Purpose: serves 32-bit reads from one 128-bit array line
// Assumes: array port on pclk, one line request at a time
// Notes:   a miss costs one array access, hits answer next cycle
`timescale 1ns/10ps
module flb_wide_read
  import flb_pkg::*;
(
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic               inval,
  input  wire logic               rd_req,
  input  wire logic [WADDR_W-1:0] rd_addr,
  output logic [31:0]             rd_data,
  output logic                    rd_valid,
  output logic                    arr_rd_req,
  output logic [WADDR_W-3:0]      arr_rd_line,
  input  wire logic [LINE_W-1:0]  arr_rd_data,
  input  wire logic               arr_rd_ack
);
  logic [LINE_W-1:0]  line_q, line_d;
  logic [WADDR_W-3:0] tag_q, tag_d;
  logic               lv_q, lv_d, req_q, req_d, vld_q, vld_d;
  logic [31:0]        dat_q, dat_d;
  logic               hit;

  assign hit = lv_q && tag_q == rd_addr[WADDR_W-1:2];

  always_comb begin
    line_d = line_q;
    tag_d  = tag_q;
    lv_d   = lv_q && !inval;
    req_d  = req_q;
    vld_d  = 1'b0;
    dat_d  = dat_q;
    if (req_q) begin
      if (arr_rd_ack) begin
        req_d  = 1'b0;
        line_d = arr_rd_data;
        lv_d   = !inval;
      end
    end else if (rd_req && hit && !inval) begin
      vld_d = 1'b1;
      dat_d = line_q[rd_addr[1:0]*32 +: 32];
    end else if (rd_req) begin
      req_d = 1'b1;
      tag_d = rd_addr[WADDR_W-1:2];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      line_q <= '0;
      tag_q  <= '0;
      lv_q   <= 1'b0;
      req_q  <= 1'b0;
      vld_q  <= 1'b0;
      dat_q  <= 32'h0000_0000;
    end else begin
      line_q <= line_d;
      tag_q  <= tag_d;
      lv_q   <= lv_d;
      req_q  <= req_d;
      vld_q  <= vld_d;
      dat_q  <= dat_d;
    end
  end

  assign rd_data     = dat_q;
  assign rd_valid    = vld_q;
  assign arr_rd_req  = req_q;
  assign arr_rd_line = tag_q;

  a_hit_answer : assert property (@(posedge pclk) disable iff (!presetn)
    !req_q && rd_req && hit && !inval |=> vld_q)
    else $error("line hit did not answer next cycle");
endmodule

// ===== flb_ctrl.sv
// Purpose: flash lock regions, general nv bits, boot map, wide read
// Assumes: 100 MHz pclk, APB slave, array ports on pclk
// Notes:   nv bits and locks survive presetn; only nv_init_n clears
//
// Local design decisions: the register addresses and the APB interface to the registers.
`timescale 1ns/10ps
module flb_ctrl
  import flb_pkg::*;
#(
  parameter int NUM_REGIONS = REGIONS_DEF
)(
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic               nv_init_n,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [7:0]         paddr,
  input  wire logic [31:0]        pwdata,
  output logic [31:0]             prdata,
  output logic                    pready,
  output logic                    pslverr,
  input  wire logic               erase_pin,
  input  wire logic               test_pin,
  input  wire logic [3:0]         port_lines,
  input  wire logic               remap,
  input  wire logic               dbg_req,
  output logic                    dbg_grant,
  input  wire logic               fpp_cmd_vld,
  input  wire logic [7:0]         fpp_cmd,
  input  wire logic [15:0]        fpp_arg,
  output logic                    fpp_cmd_ack,
  output logic                    fpp_refused,
  output logic                    fast_programming_port,
  input  wire logic               bw_en,
  input  wire logic [19:0]        bw_addr,
  input  wire logic [31:0]        bw_data,
  input  wire logic [6:0]         pbuf_idx,
  output logic [31:0]             pbuf_rdata,
  output logic                    arr_op,
  output logic [7:0]              arr_op_code,
  output logic [PAGE_W-1:0]       arr_page,
  input  wire logic               arr_done,
  input  wire logic               rd_req,
  input  wire logic [WADDR_W-1:0] rd_addr,
  output logic [31:0]             rd_data,
  output logic                    rd_valid,
  output logic                    arr_rd_req,
  output logic [WADDR_W-3:0]      arr_rd_line,
  input  wire logic [LINE_W-1:0]  arr_rd_data,
  input  wire logic               arr_rd_ack,
  output logic                    brownout_detector_en,
  output logic                    brownout_reset_en,
  output logic [1:0]              boot_target,
  output logic [15:0]             rom_prog_base
);
  initial begin
    if (!(NUM_REGIONS inside {8, 16, 32}))
      $error("NUM_REGIONS must be 8, 16 or 32");
  end
  localparam int REG_W = $clog2(NUM_REGIONS);

  function automatic logic [5:0] region_of(input logic [PAGE_W-1:0] pg);
    region_of = pg[PAGE_W-1:5];
  endfunction

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  logic [6:0] pin_m_q, pin_s_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_m_q <= 7'h00;
      pin_s_q <= 7'h00;
    end else begin
      pin_m_q <= {dbg_req, erase_pin, test_pin, port_lines};
      pin_s_q <= pin_m_q;
    end
  end
  logic erase_s, dbg_s, fpp_strap;
  assign dbg_s     = pin_s_q[6];
  assign erase_s   = pin_s_q[5];
  assign fpp_strap = pin_s_q[4] & pin_s_q[0] & pin_s_q[1]
                   & ~pin_s_q[2] & ~pin_s_q[3];

  // ****************************************************************
  // program buffer
  // ****************************************************************
  logic [31:0] pbuf_mem [PAGE_WORDS];
  logic [31:0] pbuf_q;
  always_ff @(posedge pclk) begin
    if (bw_en)
      pbuf_mem[bw_addr[8:2]] <= bw_data;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      pbuf_q <= 32'h0000_0000;
    else
      pbuf_q <= pbuf_mem[pbuf_idx];
  end
  assign pbuf_rdata = pbuf_q;

  // ****************************************************************
  // command engine, locks and nv bits
  // ****************************************************************
  flb_state_t        st_q, st_d;
  logic [31:0]       lock_q, lock_d;
  logic [3:0]        nv_q, nv_d;
  logic              erase_old_q, erase_old_d, pin_pend_q, pin_pend_d;
  logic              pin_run_q, pin_run_d, abort_q, abort_d;
  logic              op_q, op_d, fack_q, fack_d, fref_q, fref_d;
  logic [7:0]        code_q, code_d;
  logic [PAGE_W-1:0] page_q, page_d;
  logic [31:0]       res_q, res_d;
  logic              apb_cmd, apb_wr, stat_rd, go, fpp_go, fpp_rd;
  logic [7:0]        c_code;
  logic [15:0]       c_arg;
  logic [5:0]        c_reg;
  logic              c_locked, c_bad;

  assign apb_wr  = psel & penable & pready;
  assign apb_cmd = apb_wr & pwrite & (paddr == OFS_CMD);
  assign stat_rd = apb_wr & ~pwrite & (paddr == OFS_STATUS);
  // the cpu port wins; a fast port command other than CMD_RD waits for an idle engine
  assign fpp_go  = fpp_cmd_vld & fast_programming_port & ~nv_q[NV_SEC]
                 & ~apb_cmd & ~fack_q & ~fref_q;
  assign fpp_rd  = fpp_go & (fpp_cmd == CMD_RD);
  assign go      = (st_q == S_IDLE) & ~pin_pend_q
                 & (apb_cmd | (fpp_go & ~fpp_rd));
  assign c_code  = apb_cmd ? pwdata[7:0] : fpp_cmd;
  assign c_arg   = apb_cmd ? pwdata[23:8] : fpp_arg;
  assign c_reg   = region_of(c_arg[PAGE_W-1:0]);
  assign c_bad   = c_reg >= 6'(NUM_REGIONS);
  assign c_locked = lock_q[c_reg[4:0]];

  always_comb begin
    st_d        = st_q;
    lock_d      = lock_q;
    nv_d        = nv_q;
    erase_old_d = erase_s;
    pin_pend_d  = pin_pend_q;
    pin_run_d   = pin_run_q;
    abort_d     = abort_q & ~stat_rd;
    op_d        = 1'b0;
    code_d      = code_q;
    page_d      = page_q;
    res_d       = res_q;
    fack_d      = 1'b0;
    fref_d      = fpp_cmd_vld & fast_programming_port
                & nv_q[NV_SEC] & ~fref_q;
    if (fpp_rd)
      fack_d = 1'b1;
    unique case (st_q)
      S_IDLE: begin
        if (pin_pend_q) begin
          op_d       = 1'b1;
          code_d     = CMD_EA;
          pin_pend_d = 1'b0;
          pin_run_d  = 1'b1;
          st_d       = S_ARR;
        end else if (go) begin
          fack_d = ~apb_cmd;
          code_d = c_code;
          page_d = c_arg[PAGE_W-1:0];
          st_d   = S_DONE;
          unique case (c_code)
            CMD_DESC: res_d = {16'(NUM_REGIONS),
                               16'(NUM_REGIONS * REGION_PAGES)};
            CMD_WP, CMD_EWP: begin
              if (c_bad || c_locked)
                abort_d = 1'b1;
              else begin
                op_d = 1'b1;
                st_d = S_ARR;
              end
            end
            CMD_EA: begin
              if (lock_q != LOCK_RESET)
                abort_d = 1'b1;
              else begin
                op_d = 1'b1;
                st_d = S_ARR;
              end
            end
            CMD_SLB, CMD_CLB: begin
              if (c_bad)
                abort_d = 1'b1;
              else
                lock_d[c_reg[4:0]] = (c_code == CMD_SLB);
            end
            CMD_SNV: nv_d[c_arg[1:0]] = 1'b1;
            CMD_CNV: if (c_arg[1:0] != 2'(NV_SEC))
              nv_d[c_arg[1:0]] = 1'b0;
            else
              abort_d = 1'b1;
            default: abort_d = 1'b1;
          endcase
        end
      end
      S_ARR: begin
        if (arr_done) begin
          st_d = S_DONE;
          if (code_q == CMD_EA) begin
            nv_d[NV_BOOT] = 1'b0;
            if (pin_run_q && erase_s)
              nv_d[NV_SEC] = 1'b0;
            pin_run_d = 1'b0;
          end
        end
      end
      S_DONE: st_d = S_IDLE;
      default: st_d = S_IDLE;
    endcase
    // after the command decode: the erase pin beats a same-cycle command on the locks and the two brownout bits
    if (erase_s && !erase_old_q) begin
      lock_d          = LOCK_RESET;
      nv_d[NV_BOD]    = 1'b0;
      nv_d[NV_BODRST] = 1'b0;
      pin_pend_d      = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q        <= S_IDLE;
      erase_old_q <= 1'b0;
      pin_pend_q  <= 1'b0;
      pin_run_q   <= 1'b0;
      abort_q     <= 1'b0;
      op_q        <= 1'b0;
      code_q      <= CMD_DESC;
      page_q      <= '0;
      res_q       <= 32'h0000_0000;
      fack_q      <= 1'b0;
      fref_q      <= 1'b0;
    end else begin
      st_q        <= st_d;
      erase_old_q <= erase_old_d;
      pin_pend_q  <= pin_pend_d;
      pin_run_q   <= pin_run_d;
      abort_q     <= abort_d;
      op_q        <= op_d;
      code_q      <= code_d;
      page_q      <= page_d;
      res_q       <= res_d;
      fack_q      <= fack_d;
      fref_q      <= fref_d;
    end
  end

  // nonvolatile image: untouched by presetn, only blank-array init
  always_ff @(posedge pclk or negedge nv_init_n) begin
    if (!nv_init_n) begin
      nv_q   <= NV_RESET;
      lock_q <= LOCK_RESET;
    end else begin
      nv_q   <= nv_d;
      lock_q <= lock_d;
    end
  end

  assign arr_op      = op_q;
  assign arr_op_code = code_q;
  assign arr_page    = page_q;
  assign fpp_cmd_ack = fack_q;
  assign fpp_refused = fref_q;

  // ****************************************************************
  // boot map, brownout and access gates
  // ****************************************************************
  logic       bs_done_q, bs_q, fpp_q, dgr_q, bod_q, bodr_q;
  logic [1:0] boot_q;
  logic [15:0] rom_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bs_done_q <= 1'b0;
      bs_q      <= 1'b0;
      fpp_q     <= 1'b0;
      dgr_q     <= 1'b0;
      bod_q     <= 1'b0;
      bodr_q    <= 1'b0;
      boot_q    <= BOOT_ROM;
      rom_q     <= 16'h0000;
    end else begin
      bs_done_q <= 1'b1;
      if (!bs_done_q)
        bs_q <= nv_q[NV_BOOT];
      fpp_q  <= fpp_strap;
      dgr_q  <= dbg_s & ~nv_q[NV_SEC];
      bod_q  <= nv_q[NV_BOD];
      bodr_q <= nv_q[NV_BODRST];
      boot_q <= remap ? BOOT_SRAM
              : (bs_q ? BOOT_FLASH : BOOT_ROM);
      rom_q  <= fpp_strap ? ROM_SLOT : 16'h0000;
    end
  end
  assign fast_programming_port = fpp_q;
  assign dbg_grant             = dgr_q;
  assign brownout_detector_en  = bod_q;
  assign brownout_reset_en     = bodr_q;
  assign boot_target           = boot_q;
  assign rom_prog_base         = rom_q;

  flb_wide_read u_rd (
    .pclk        (pclk),
    .presetn     (presetn),
    .inval       (op_q),
    .rd_req      (rd_req),
    .rd_addr     (rd_addr),
    .rd_data     (rd_data),
    .rd_valid    (rd_valid),
    .arr_rd_req  (arr_rd_req),
    .arr_rd_line (arr_rd_line),
    .arr_rd_data (arr_rd_data),
    .arr_rd_ack  (arr_rd_ack)
  );

  // ****************************************************************
  // apb slave, one wait-free access cycle
  // ****************************************************************
  logic [31:0] prd_q, prd_d;
  logic        prdy_q, prdy_d, perr_q, perr_d;
  always_comb begin
    prd_d  = prd_q;
    prdy_d = 1'b0;
    perr_d = 1'b0;
    if (psel && !penable) begin
      prdy_d = 1'b1;
      prd_d  = 32'h0000_0000;
      unique case (paddr)
        OFS_CMD: ;
        OFS_STATUS: prd_d = {28'h000_0000, fpp_q, nv_q[NV_SEC],
                             abort_q, st_q == S_IDLE && !pin_pend_q};
        OFS_RESULT: prd_d = res_q;
        OFS_LOCKS:  prd_d = lock_q;
        OFS_NVBITS: prd_d = {28'h000_0000, nv_q};
        OFS_BOOT:   prd_d = {28'h000_0000, bs_q, remap, boot_q};
        default:    perr_d = 1'b1;
      endcase
      if (!pwrite && paddr == OFS_CMD)
        perr_d = 1'b1;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prd_q  <= 32'h0000_0000;
      prdy_q <= 1'b0;
      perr_q <= 1'b0;
    end else begin
      prd_q  <= prd_d;
      prdy_q <= prdy_d;
      perr_q <= perr_d;
    end
  end
  assign prdata  = prd_q;
  assign pready  = prdy_q;
  assign pslverr = perr_q;

  // ****************************************************************
  // assertions
  // ****************************************************************
  sequence s_lockcmd;
    go && (c_code == CMD_WP || c_code == CMD_EWP) && !c_bad && c_locked;
  endsequence
  sequence s_pin_rise;
    erase_s && !erase_old_q;
  endsequence
  a_abort_locked : assert property (@(posedge pclk) disable iff (!presetn)
    s_lockcmd |=> abort_q && !op_q ##1 st_q == S_IDLE)
    else $error("locked program not aborted");
  a_pin_unlock : assert property (@(posedge pclk) disable iff (!presetn)
    s_pin_rise |=> lock_q == LOCK_RESET && !nv_q[NV_BOD]
    && !nv_q[NV_BODRST])
    else $error("erase pin left locks or brownout bits");
  a_sec_clear : assert property (@(posedge pclk) disable iff (!presetn)
    $fell(nv_q[NV_SEC]) && nv_init_n |-> $past(pin_run_q)
    && $past(arr_done))
    else $error("security cleared without pin erase");
  a_dbg_block : assert property (@(posedge pclk) disable iff (!presetn)
    nv_q[NV_SEC] [*2] |-> !dgr_q)
    else $error("debug granted while secure");
  a_bod_follow : assert property (@(posedge pclk) disable iff (!presetn)
    $past(presetn) |-> bod_q == $past(nv_q[NV_BOD])
    && bodr_q == $past(nv_q[NV_BODRST]))
    else $error("brownout controls lag nv bits");
  a_boot_map : assert property (@(posedge pclk) disable iff (!presetn)
    $past(remap) |-> boot_q == BOOT_SRAM)
    else $error("remap did not select sram");
  a_lock_set : assert property (@(posedge pclk) disable iff (!presetn)
    go && c_code == CMD_SLB && !c_bad |=> lock_q[$past(c_reg[4:0])])
    else $error("set-lock did not set the bit");
  a_erase_boot : assert property (@(posedge pclk) disable iff (!presetn)
    st_q == S_ARR && arr_done && code_q == CMD_EA |=> !nv_q[NV_BOOT])
    else $error("boot select survived full erase");
  a_apb_ready : assert property (@(posedge pclk) disable iff (!presetn)
    psel && !penable |=> pready ##1 !pready)
    else $error("apb access not one cycle");
endmodule

// ===== flb_array_model.sv
// Purpose: flash array partner facing the controller's array ports
// Assumes: pclk domain, op done and line ack after fixed delays
// Notes:   line words carry their line and word index as a pattern
`timescale 1ns/10ps
module flb_array_model
  import flb_pkg::*;
(
  input  wire logic               pclk,
  input  wire logic               arr_op,
  input  wire logic               arr_rd_req,
  input  wire logic [WADDR_W-3:0] arr_rd_line,
  output logic                    arr_done,
  output logic [LINE_W-1:0]       arr_rd_data,
  output logic                    arr_rd_ack
);
  int op_cnt = 0;
  int rd_cnt = 0;
  initial begin
    arr_done = 1'b0;
    arr_rd_ack = 1'b0;
    arr_rd_data = '0;
  end
  always @(posedge pclk) begin
    arr_done <= (op_cnt == 1);
    if (arr_op === 1'b1) op_cnt <= 5;
    else if (op_cnt > 0) op_cnt <= op_cnt - 1;
    arr_rd_ack <= 1'b0;
    if (arr_rd_req === 1'b1 && !arr_rd_ack) begin
      rd_cnt <= rd_cnt + 1;
      if (rd_cnt == 3) begin
        rd_cnt <= 0;
        arr_rd_ack <= 1'b1;
        for (int w = 0; w < 4; w++) begin
          arr_rd_data[32*w +: 32] <= {8'hA5, 6'h0, arr_rd_line, w[1:0]};
        end
      end
    end else begin
      // outside a pending request the last line is inverted every cycle; it holds while a request waits
      arr_rd_data <= ~arr_rd_data;
    end
  end
endmodule

// ===== tb_top.sv
// Purpose: self-checking bench for the flash lock and nv bit controller
// Assumes: commands complete when STATUS ready reads back high
// Notes:   rows hold plain commands, hand tests the awkward cases
`timescale 1ns/10ps
module tb_top;
  import flb_pkg::*;
  typedef struct packed {
    logic [7:0] code; logic [15:0] arg; logic [7:0] ofs; logic [31:0] exp;
  } flb_row_t;
  logic pclk = 0, presetn = 0, nv_init_n = 0, psel = 0, penable = 0;
  logic pwrite = 0, erase_pin = 0, test_pin = 0, remap = 0, dbg_req = 0;
  logic fpp_cmd_vld = 0, bw_en = 0, rd_req = 0, err, ab;
  logic [7:0] paddr = '0, fpp_cmd = '0, arr_op_code;
  logic [15:0] fpp_arg = '0, rom_prog_base;
  logic [31:0] pwdata = '0, bw_data = '0, prdata, pbuf_rdata, rd_data, rd;
  logic [3:0] port_lines = '0;
  logic [19:0] bw_addr = '0;
  logic [6:0] pbuf_idx = '0;
  logic [WADDR_W-1:0] rd_addr = '0;
  logic pready, pslverr, dbg_grant, fpp_cmd_ack, fpp_refused, arr_op;
  logic fast_programming_port, arr_done, rd_valid, arr_rd_req, arr_rd_ack;
  logic brownout_detector_en, brownout_reset_en;
  logic [PAGE_W-1:0] arr_page;
  logic [WADDR_W-3:0] arr_rd_line;
  logic [LINE_W-1:0] arr_rd_data;
  logic [1:0] boot_target;
  int n_errors = 0, checks = 0, n_op = 0, n_ack = 0, n0, i;
  flb_row_t rows [7] = '{
    {CMD_SNV, 16'h1, OFS_NVBITS, 32'h2}, {CMD_SNV, 16'h2, OFS_NVBITS, 32'h6},
    {CMD_SLB, 16'h20, OFS_LOCKS, 32'h2}, {CMD_SLB, 16'h1F, OFS_LOCKS, 32'h3},
    {CMD_CLB, 16'h3F, OFS_LOCKS, 32'h1}, {CMD_CNV, 16'h2, OFS_NVBITS, 32'h2},
    {CMD_DESC, 16'h0, OFS_RESULT, 32'h0020_0400}};
  flb_ctrl i_dut (.pclk, .presetn, .nv_init_n, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .erase_pin, .test_pin,
    .port_lines, .remap, .dbg_req, .dbg_grant, .fpp_cmd_vld, .fpp_cmd,
    .fpp_arg, .fpp_cmd_ack, .fpp_refused, .fast_programming_port, .bw_en,
    .bw_addr, .bw_data, .pbuf_idx, .pbuf_rdata, .arr_op, .arr_op_code,
    .arr_page, .arr_done, .rd_req, .rd_addr, .rd_data, .rd_valid,
    .arr_rd_req, .arr_rd_line, .arr_rd_data, .arr_rd_ack,
    .brownout_detector_en, .brownout_reset_en, .boot_target, .rom_prog_base);
  flb_array_model i_arr (.pclk, .arr_op, .arr_rd_req, .arr_rd_line,
    .arr_done, .arr_rd_data, .arr_rd_ack);
  always #5 pclk = ~pclk;
  always @(posedge pclk) begin
    if (arr_op === 1'b1) n_op++;
    if (arr_rd_ack === 1'b1) n_ack++;
  end
  // ****************************************************************
  // tasks
  // ****************************************************************
  task automatic close_out();
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic tmo();
    n_errors++;
    $display("FAIL wait exp answer got none");
    close_out();
  endtask
  task automatic chk(string nm, logic [31:0] e, logic [31:0] s);
    checks++;
    if (s !== e) begin
      n_errors++;
      $display("FAIL %s exp %h got %h", nm, e, s);
    end
  endtask
  task automatic apb(logic wr, logic [7:0] a, logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (k = 0; k < 20; k++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (k == 20) tmo();
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic poll();
    int k;
    for (k = 0; k < 50; k++) begin
      apb(1'b0, OFS_STATUS, 32'h0);
      ab |= rd[ST_ABORT];
      if (rd[ST_READY] === 1'b1) break;
    end
    if (k == 50) tmo();
  endtask
  task automatic cmd(logic [7:0] c, logic [15:0] a);
    apb(1'b1, OFS_CMD, {8'h0, a, c});
    poll();
  endtask
  task automatic fpp(logic [7:0] c, logic [15:0] a);
    int k;
    @(posedge pclk);
    fpp_cmd_vld <= 1'b1;
    fpp_cmd <= c;
    fpp_arg <= a;
    for (k = 0; k < 20; k++) begin
      @(posedge pclk);
      if (fpp_cmd_ack === 1'b1 || fpp_refused === 1'b1) break;
    end
    if (k == 20) tmo();
    err = fpp_refused;
    fpp_cmd_vld <= 1'b0;
  endtask
  task automatic rdw(logic [WADDR_W-1:0] a);
    int k;
    @(posedge pclk);
    rd_req <= 1'b1;
    rd_addr <= a;
    for (k = 0; k < 30; k++) begin
      @(posedge pclk);
      if (rd_valid === 1'b1) break;
    end
    if (k == 30) tmo();
    rd = rd_data;
    rd_req <= 1'b0;
  endtask
  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    nv_init_n <= 1'b1;
    apb(1'b0, OFS_NVBITS, 32'h0);
    chk("nvbits reset", {28'h0, NV_RESET}, rd);
    chk("boot reset", BOOT_ROM, boot_target);
    foreach (rows[r]) begin
      cmd(rows[r].code, rows[r].arg);
      apb(1'b0, rows[r].ofs, 32'h0);
      chk("row", rows[r].exp, rd);
    end
    chk("bod en", 1'b1, brownout_detector_en);
    chk("bod rst", 1'b0, brownout_reset_en);
    cmd(CMD_SNV, 16'h2);
    chk("bod rst on", 1'b1, brownout_reset_en);
    ab = 1'b0;
    n0 = n_op;
    cmd(CMD_EWP, 16'h5);
    chk("abort", 1'b1, ab);
    chk("no op", n0, n_op);
    cmd(CMD_CLB, 16'h5);
    ab = 1'b0;
    cmd(CMD_EWP, 16'h5);
    chk("op after unlock", n0 + 1, n_op);
    chk("op page", 11'h5, arr_page);
    apb(1'b0, 8'h18, 32'h0);
    chk("unmapped", 1'b1, err);
    @(posedge pclk);
    bw_en <= 1'b1;
    bw_addr <= 20'hF_FE08;
    bw_data <= 32'hC0DE_0042;
    pbuf_idx <= 7'h2;
    @(posedge pclk);
    bw_en <= 1'b0;
    repeat (2) @(posedge pclk);
    chk("page buffer", 32'hC0DE_0042, pbuf_rdata);
    rdw(18'h0_0105);
    chk("line word", {8'hA5, 6'h0, 16'h0041, 2'h1}, rd);
    n0 = n_ack;
    rdw(18'h0_0106);
    chk("hit word", {8'hA5, 6'h0, 16'h0041, 2'h2}, rd);
    chk("no refetch", n0, n_ack);
    remap <= 1'b1;
    repeat (3) @(posedge pclk);
    chk("remap sram", BOOT_SRAM, boot_target);
    remap <= 1'b0;
    cmd(CMD_SNV, 16'h3);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    chk("boot flash", BOOT_FLASH, boot_target);
    chk("bod kept", 1'b1, brownout_detector_en);
    test_pin <= 1'b1;
    port_lines <= 4'h3;
    repeat (6) @(posedge pclk);
    chk("fast mode", 1'b1, fast_programming_port);
    chk("rom slot", ROM_SLOT, rom_prog_base);
    for (int c = 0; c < 6; c++) begin
      fpp(c == 0 ? CMD_RD : c == 1 ? CMD_WP : c == 2 ? CMD_EWP :
          c == 3 ? CMD_SLB : c == 4 ? CMD_CLB : CMD_SNV, 16'h0);
      chk("fast cmd", 1'b0, err);
      poll();
    end
    cmd(CMD_CNV, 16'h0);
    apb(1'b0, OFS_NVBITS, 32'h0);
    chk("sec kept", 1'b1, rd[NV_SEC]);
    fpp(CMD_RD, 16'h0);
    chk("secured", 1'b1, err);
    dbg_req <= 1'b1;
    cmd(CMD_SLB, 16'h40);
    chk("debug blocked", 1'b0, dbg_grant);
    n0 = n_op;
    erase_pin <= 1'b1;
    for (i = 0; i < 40 && n_op == n0; i++) @(posedge pclk);
    if (n_op == n0) tmo();
    chk("erase code", CMD_EA, arr_op_code);
    poll();
    erase_pin <= 1'b0;
    apb(1'b0, OFS_LOCKS, 32'h0);
    chk("locks erased", 32'h0, rd);
    apb(1'b0, OFS_NVBITS, 32'h0);
    chk("nv erased", 32'h0, rd);
    chk("debug freed", 1'b1, dbg_grant);
    close_out();
  end
endmodule
